// ===== irg_pkg.sv
`default_nettype none
package irg_pkg;
	// Timing of the system clock and of the two qualifying filters.
	localparam longint unsigned CLK_PERIOD_NS = 64'd10;
	localparam longint unsigned NOISE_TIME_MS = 64'd1000;
	localparam longint unsigned AUTH_TIME_MS = 64'd2000;
	localparam int unsigned NOISE_CYC = 32'((NOISE_TIME_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);
	localparam int unsigned AUTH_CYC = 32'((AUTH_TIME_MS * 64'd1000000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS);

	// Register byte offsets on the APB.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PIN_CNT = 8'h08;
	localparam logic [7:0] REG_KEY_CNT = 8'h0c;

	// Control register fields and reset values.
	localparam int CTRL_OPT_LSB = 0;
	localparam int CTRL_AUTH_BIT = 2;
	localparam logic [1:0] CTRL_OPT_RST = 2'h0;
	localparam logic CTRL_AUTH_RST = 1'b0;

	// Status register fields.
	localparam int ST_INIT_BIT = 0;
	localparam int ST_POR_BIT = 1;
	localparam int ST_PIN_BIT = 2;
	localparam int ST_KEY_BIT = 3;
	localparam int ST_OSC_BIT = 4;
	localparam int ST_HIT_BIT = 5;

	// Core values loaded by an initial reset.
	localparam logic [7:0] INIT_PSC = 8'h00;
	localparam logic [3:0] INIT_PPC = 4'h1;
	localparam logic [3:0] INIT_NEXT_PAGE = 4'h1;
	localparam logic INIT_IFLAG = 1'b0;
	localparam logic INIT_DFLAG = 1'b0;

	// Key-line combination options.
	typedef enum logic [1:0] {
		IRG_OPT_OFF,
		IRG_OPT_TWO,
		IRG_OPT_THREE,
		IRG_OPT_FOUR
	} irg_opt_t;

	// Values handed to the core while it is held in reset.
	typedef struct packed {
		logic [7:0] program_step_counter;
		logic [3:0] program_page_counter;
		logic [3:0] next_page_pointer;
		logic iflag;
		logic dflag;
	} irg_core_init_t;
endpackage
`default_nettype wire

// ===== irg_filter.sv
`timescale 1ns/1ps
`default_nettype none
module irg_filter #(
	parameter int CNT_W = 32
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic level_i,
	input wire logic [CNT_W-1:0] thr_i,
	output var logic qual_o,
	output var logic [CNT_W-1:0] cnt_o
);
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic qual_q, qual_d;

	// Count cycles of a continuous high level; any low sample restarts the count.
	assign cnt_d = !level_i ? '0 : (qual_q ? cnt_q : cnt_q + 1'b1);
	assign qual_d = level_i && (qual_q || cnt_q == thr_i - 1'b1);

	// Counter and qualified flag.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			qual_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			qual_q <= qual_d;
		end
	end

	assign qual_o = qual_q;
	assign cnt_o = cnt_q;
endmodule
`default_nettype wire

// ===== irg_top.sv
// Summary of operation
// - Power-on reset holds until oscillator runs.
// - Reset from power-on, pin, or key lines.
// - CPU runs once reset pin falls.
// - Key option: off, two, three, four lines.
// - Authorizer demands longer continuous key high.
// - Reset loads step, page, pointer, flags.
`timescale 1ns/1ps
`default_nettype none
module irg_top #(
	parameter int unsigned NOISE_CYCLES = irg_pkg::NOISE_CYC,
	parameter int unsigned AUTH_CYCLES = irg_pkg::AUTH_CYC
) (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic OSC_RUN_I,
	input wire logic RESET_PIN_I,
	input wire logic [3:0] KEY_INPUT_LINES_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output var logic [31:0] PRDATA_O,
	output var logic PREADY_O,
	output var logic PSLVERR_O,
	output var logic INIT_RESET_O,
	output var logic CPU_RUN_O,
	output var irg_pkg::irg_core_init_t CORE_INIT_O
);
	// Registered state.
	logic por_q;
	logic init_q, init_d;
	logic run_q;
	irg_pkg::irg_opt_t opt_q;
	logic auth_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	irg_pkg::irg_core_init_t core_q;

	// Decoded and combinational signals.
	wire logic [3:0] key_mask;
	wire logic key_hit;
	wire logic pin_qual;
	wire logic key_qual;
	wire logic [31:0] pin_cnt;
	wire logic [31:0] key_cnt;
	wire logic [31:0] key_thr;
	wire logic pin_src;
	wire logic key_src;
	wire logic setup;
	wire logic access;
	wire logic wr_ctrl;
	wire logic hit_ctrl, hit_status, hit_pcnt, hit_kcnt, mapped;
	wire logic [31:0] ctrl_word, status_word, rd_word;

	// Lines that the selected option requires high.
	function automatic logic [3:0] opt_mask(input irg_pkg::irg_opt_t opt);
		unique case (opt)
			irg_pkg::IRG_OPT_OFF: opt_mask = 4'h0;
			irg_pkg::IRG_OPT_TWO: opt_mask = 4'h3;
			irg_pkg::IRG_OPT_THREE: opt_mask = 4'h7;
			irg_pkg::IRG_OPT_FOUR: opt_mask = 4'hf;
		endcase
	endfunction

	// Key-line combination: disabled option never hits, otherwise all selected lines high.
	assign key_mask = opt_mask(opt_q);
	assign key_hit = (key_mask != 4'h0) && ((KEY_INPUT_LINES_I & key_mask) == key_mask);
	// With the authorizer on, the key count must reach the longer time.
	assign key_thr = auth_q ? AUTH_CYCLES : NOISE_CYCLES;

	// Noise rejector on the reset pin.
	irg_filter #(
		.CNT_W(32)
	) u_pin_filter (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.level_i(RESET_PIN_I),
		.thr_i(NOISE_CYCLES),
		.qual_o(pin_qual),
		.cnt_o(pin_cnt)
	);

	// Noise rejector and optional time authorizer on the key lines.
	irg_filter #(
		.CNT_W(32)
	) u_key_filter (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.level_i(key_hit),
		.thr_i(key_thr),
		.qual_o(key_qual),
		.cnt_o(key_cnt)
	);

	// A qualified source stays active only while its input is still high.
	assign pin_src = pin_qual && RESET_PIN_I;
	assign key_src = key_qual && key_hit;
	assign init_d = por_q || pin_src || key_src;

	// Power-on hold: set by the power-on reset, released when the oscillator runs.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			por_q <= 1'b1;
		end else if (OSC_RUN_I) begin
			por_q <= 1'b0;
		end
	end

	// Initial reset output and CPU run enable.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			init_q <= 1'b1;
			run_q <= 1'b0;
		end else begin
			init_q <= init_d;
			run_q <= !init_d;
		end
	end

	// Core start values, loaded whenever initial reset is in force.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I || init_d) begin
			core_q.program_step_counter <= irg_pkg::INIT_PSC;
			core_q.program_page_counter <= irg_pkg::INIT_PPC;
			core_q.next_page_pointer <= irg_pkg::INIT_NEXT_PAGE;
			core_q.iflag <= irg_pkg::INIT_IFLAG;
			core_q.dflag <= irg_pkg::INIT_DFLAG;
		end
	end

	// APB decode.
	assign setup = PSEL_I && !PENABLE_I;
	assign access = PSEL_I && PENABLE_I && pready_q;
	assign hit_ctrl = PADDR_I == irg_pkg::REG_CTRL;
	assign hit_status = PADDR_I == irg_pkg::REG_STATUS;
	assign hit_pcnt = PADDR_I == irg_pkg::REG_PIN_CNT;
	assign hit_kcnt = PADDR_I == irg_pkg::REG_KEY_CNT;
	assign mapped = hit_ctrl || hit_status || hit_pcnt || hit_kcnt;
	assign wr_ctrl = access && PWRITE_I && hit_ctrl && !pslverr_q;

	// Read words; unused bits read as zero.
	assign ctrl_word = {29'h0, auth_q, opt_q};
	assign status_word = {26'h0, key_hit, OSC_RUN_I, key_src, pin_src, por_q, init_q};
	assign rd_word = hit_ctrl ? ctrl_word :
		hit_status ? status_word :
		hit_pcnt ? pin_cnt :
		hit_kcnt ? key_cnt : 32'h0;

	// Answer one cycle after setup; unmapped addresses answer with an error.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !mapped;
			prdata_q <= (setup && !PWRITE_I) ? rd_word : 32'h0;
		end
	end

	// Control register; cleared by the power-on reset only, not by initial reset.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			opt_q <= irg_pkg::irg_opt_t'(irg_pkg::CTRL_OPT_RST);
			auth_q <= irg_pkg::CTRL_AUTH_RST;
		end else if (wr_ctrl) begin
			opt_q <= irg_pkg::irg_opt_t'(PWDATA_I[irg_pkg::CTRL_OPT_LSB +: 2]);
			auth_q <= PWDATA_I[irg_pkg::CTRL_AUTH_BIT];
		end
	end

	assign PRDATA_O = prdata_q;
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;
	assign INIT_RESET_O = init_q;
	assign CPU_RUN_O = run_q;
	assign CORE_INIT_O = core_q;

	// Helper sequence: the pin falls after having qualified.
	sequence seq_pin_release;
		pin_qual ##1 !RESET_PIN_I;
	endsequence

	// Helper sequence: a clean power-on with a running oscillator.
	sequence seq_osc_start;
		OSC_RUN_I && !pin_src && !key_src;
	endsequence

	chk_por_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(por_q && !OSC_RUN_I) |=> INIT_RESET_O && por_q)
		else $error("power-on hold released without oscillator");

	chk_por_release: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		seq_osc_start ##1 (!pin_src && !key_src) |=> !INIT_RESET_O)
		else $error("reset not released after oscillator start");

	chk_src_reset: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		(pin_src || key_src) |=> INIT_RESET_O && !CPU_RUN_O)
		else $error("qualified source did not assert reset");

	chk_pin_run: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		seq_pin_release ##0 (!por_q && !key_src) |=> CPU_RUN_O && !INIT_RESET_O)
		else $error("cpu did not start after pin release");

	chk_key_decode: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		key_hit |-> (opt_q != irg_pkg::IRG_OPT_OFF) && KEY_INPUT_LINES_I[0] && KEY_INPUT_LINES_I[1]
		&& (opt_q < irg_pkg::IRG_OPT_THREE || KEY_INPUT_LINES_I[2])
		&& (opt_q != irg_pkg::IRG_OPT_FOUR || KEY_INPUT_LINES_I[3]))
		else $error("key combination decoded wrongly");

	chk_key_time: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		$rose(key_qual) |-> $past(key_cnt) == (($past(auth_q) ? AUTH_CYCLES : NOISE_CYCLES) - 32'd1))
		else $error("key source qualified at wrong count");

	chk_pin_time: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		$rose(pin_qual) |-> $past(pin_cnt) == NOISE_CYCLES - 32'd1 && $past(RESET_PIN_I))
		else $error("pin qualified at wrong count");

	chk_core_init: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		init_d |=> CORE_INIT_O.program_step_counter == 8'h00 && CORE_INIT_O.program_page_counter == 4'h1
		&& CORE_INIT_O.next_page_pointer == 4'h1 && !CORE_INIT_O.iflag && !CORE_INIT_O.dflag)
		else $error("core start values wrong during reset");
endmodule
`default_nettype wire

// ===== irg_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module irg_src_model (
	input wire logic clk_i,
	output var logic pin_o,
	output var logic [3:0] keys_o
);
	// The test input is not modelled: the system keeps it grounded in normal operation.
	// Lines rest low, as pulled down, so a released source never reads high.
	initial begin
		pin_o = 1'b0;
		keys_o = 4'h0;
	end
	// Holds pin and keys for n samples, then releases both to the low level.
	task automatic drive(input logic p, input logic [3:0] k, input int n);
		@(posedge clk_i);
		pin_o <= p;
		keys_o <= k;
		repeat (n) @(posedge clk_i);
		pin_o <= 1'b0;
		keys_o <= 4'h0;
	endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int NC = 8;
	localparam int AC = 20;
	logic CLK_I;
	logic RST_N_I;
	logic OSC_RUN_I;
	logic RESET_PIN_I;
	logic [3:0] KEY_INPUT_LINES_I;
	logic PSEL_I;
	logic PENABLE_I;
	logic PWRITE_I;
	logic [7:0] PADDR_I;
	logic [31:0] PWDATA_I;
	logic [31:0] PRDATA_O;
	logic PREADY_O;
	logic PSLVERR_O;
	logic INIT_RESET_O;
	logic CPU_RUN_O;
	irg_pkg::irg_core_init_t CORE_INIT_O;
	logic [31:0] rd;
	logic err;
	int init_edges = 0;
	int fail_count = 0;
	int compares = 0;
	irg_top #(.NOISE_CYCLES(NC), .AUTH_CYCLES(AC)) irg_top_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
		.OSC_RUN_I(OSC_RUN_I), .RESET_PIN_I(RESET_PIN_I), .KEY_INPUT_LINES_I(KEY_INPUT_LINES_I),
		.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
		.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
		.INIT_RESET_O(INIT_RESET_O), .CPU_RUN_O(CPU_RUN_O), .CORE_INIT_O(CORE_INIT_O));
	irg_src_model irg_src_model_i (.clk_i(CLK_I), .pin_o(RESET_PIN_I), .keys_o(KEY_INPUT_LINES_I));
	// A 100 MHz clock.
	initial CLK_I = 1'b0;
	always #5 CLK_I = ~CLK_I;
	// Counts the clock edges at which the initial reset is seen high.
	always @(posedge CLK_I) if (INIT_RESET_O === 1'b1) init_edges <= init_edges + 1;
	// Counts and reports one mismatch of any word or flag.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data and error flag land in rd and err.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLK_I);
		PENABLE_I <= 1'b1;
		do begin
			@(posedge CLK_I);
		end while (PREADY_O !== 1'b1);
		rd = PRDATA_O;
		err = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	// Sets the key option, drives the sources, and checks the outcome.
	task automatic trial(input logic [31:0] c, input logic p, input logic [3:0] k, input int n, input logic e);
		int base;
		apb(1'b1, irg_pkg::REG_CTRL, c);
		base = init_edges;
		irg_src_model_i.drive(p, k, n);
		repeat (3) @(posedge CLK_I);
		chk({31'h0, init_edges != base}, {31'h0, e});
		chk({31'h0, CPU_RUN_O}, 32'h1);
	endtask
	task print_verdict;
		if (fail_count == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		RST_N_I = 1'b0;
		OSC_RUN_I = 1'b0;
		PSEL_I = 1'b0;
		PENABLE_I = 1'b0;
		PWRITE_I = 1'b0;
		PADDR_I = 8'h00;
		PWDATA_I = 32'h0;
		repeat (6) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		repeat (10) @(posedge CLK_I);
		chk({31'h0, INIT_RESET_O}, 32'h1);
		chk({14'h0, CORE_INIT_O}, {14'h0, 8'h00, 4'h1, 4'h1, 2'b00});
		apb(1'b0, irg_pkg::REG_STATUS, 32'h0);
		chk(rd, (32'h1 << irg_pkg::ST_INIT_BIT) | (32'h1 << irg_pkg::ST_POR_BIT));
		OSC_RUN_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		chk({31'h0, CPU_RUN_O}, 32'h1);
		apb(1'b0, irg_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h1 << irg_pkg::ST_OSC_BIT);
		apb(1'b0, irg_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h0);
		trial(32'h0, 1'b1, 4'h0, NC - 1, 1'b0);
		trial(32'h0, 1'b1, 4'h0, NC + 2, 1'b1);
		// Pin held high: count and status are read while the reset stands.
		fork
			irg_src_model_i.drive(1'b1, 4'h0, 20);
			begin
				repeat (NC + 3) @(posedge CLK_I);
				apb(1'b0, irg_pkg::REG_PIN_CNT, 32'h0);
				chk(rd, NC);
				apb(1'b0, irg_pkg::REG_STATUS, 32'h0);
				chk(rd, (32'h1 << irg_pkg::ST_INIT_BIT) | (32'h1 << irg_pkg::ST_PIN_BIT)
					| (32'h1 << irg_pkg::ST_OSC_BIT));
				chk({31'h0, CPU_RUN_O}, 32'h0);
			end
		join
		repeat (3) @(posedge CLK_I);
		chk({31'h0, CPU_RUN_O}, 32'h1);
		trial(32'h0, 1'b0, 4'hf, NC + 2, 1'b0);
		for (int o = 1; o < 4; o++) begin
			trial(o, 1'b0, 4'((5'h1 << (o + 1)) - 5'h1), NC + 2, 1'b1);
			trial(o, 1'b0, 4'((5'h1 << o) - 5'h1), NC + 2, 1'b0);
			trial(o, 1'b0, 4'((5'h1 << (o + 1)) - 5'h1), NC - 1, 1'b0);
		end
		apb(1'b0, irg_pkg::REG_KEY_CNT, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h0);
		trial(32'h7, 1'b0, 4'hf, AC - 2, 1'b0);
		trial(32'h7, 1'b0, 4'hf, AC + 2, 1'b1);
		apb(1'b1, 8'h10, 32'h1);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, irg_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h7);
		print_verdict;
	end
	// Cuts a hung run short.
	initial begin
		repeat (20000) @(posedge CLK_I);
		fail_count++;
		print_verdict;
	end
endmodule
`default_nettype wire
